// ### core/arseq_defines.vh
// Overview of operation
// - one to four shots, each shot with its own dead interval
// - enabled only if function on, contact assigned, unblocked, not locked, timer idle
// - breaker open after initiating trip starts dead timer; expiry closes, counts, adjusts
// - lockout when shot limit already reached and another trip occurs; default one
// - breaker failure forces lockout at any time
// - lockout disables reclosing and restores initial protection settings
// - lockout cleared by panel, input, comms reset, or qualified manual close
// - reset timer from first initiation clears shot count and settings on expiry
// - repeated trip-reclose-reset cycle restores settings but keeps shot count
// - manual close blocks reclosing for interval; clean expiry clears lockout and count
// - external-close detection treats open-to-closed transition as manual close
// - incomplete-sequence timer abandons initiation if close conditions stay unmet
// - reclose blocked if breaker not open, close block, or sync check blocking
// - enabled, in-progress and lockout each drive configurable aux relays 3 to 7
// - in-progress indication from initiation until close command issued
// - overcurrent initiation accepted only from trip-and-reclose elements
// - reclose count over sliding hour above limit forces lockout
//
// Purpose: constants of the autoreclose sequencer
// Assumes: 20 MHz core clock, one-second tick derived from it
// Notes: interval settings are given in whole seconds (dead time in 10 ms units)
`ifndef ARSEQ_DEFINES_VH
`define ARSEQ_DEFINES_VH
`define ARSEQ_CLK_HZ 20000000
`define ARSEQ_TICK_MS 10
`define ARSEQ_TICK_CYC ((`ARSEQ_CLK_HZ / 1000) * `ARSEQ_TICK_MS)
`define ARSEQ_SEC_TICKS 100
`define ARSEQ_HOUR_S 3600
`define ARSEQ_HOUR_SLOTS 60
`define ARSEQ_SLOT_S (`ARSEQ_HOUR_S / `ARSEQ_HOUR_SLOTS)
`define ARSEQ_SHOT_LIMIT_RST 3'h1
`define ARSEQ_RESET_S_RST 10'h03c
`define ARSEQ_MC_BLOCK_S_RST 8'h0a
`define ARSEQ_TIMEOUT_S_RST 10'h01e
`define ARSEQ_PUMP_LIMIT 2'h2
`endif

// ### core/arseq_tick.v
// Purpose: divider giving one-cycle enable pulses
// Assumes: single clock, synchronous reset copy
// Notes: period parameter sets the pulse spacing
`timescale 1ns/1ps
module arseq_tick #(
    parameter PERIOD = 200000
) (
    input wire core_clk,
    input wire rst_n,
    input wire en,
    output reg tick_q
);
    reg [31:0] cnt_q;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else if (!en) begin
            tick_q <= 1'b0;
        end else if (cnt_q == PERIOD - 1) begin
            cnt_q <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end
endmodule // arseq_tick

// ### core/arseq_top.v
// Purpose: feeder breaker autoreclose sequencer
// Assumes: all inputs synchronous to core_clk; settings held steady in operation
// Notes: dead times in 10 ms units, other intervals in seconds
`timescale 1ns/1ps
`include "arseq_defines.vh"
module arseq_top #(
    parameter TICK_CYC = `ARSEQ_TICK_CYC,
    parameter SEC_TICKS = `ARSEQ_SEC_TICKS
) (
    input wire core_clk,
    input wire rst_n,
    input wire reclose_scheme_enable,
    input wire [2:0] shot_limit,
    input wire [9:0] sequence_reset_interval,
    input wire [7:0] manual_close_block_interval,
    input wire external_close_detect_enable,
    input wire [9:0] shot_timeout_interval,
    input wire [5:0] hourly_reclose_limit,
    input wire [14:0] dead_interval_1,
    input wire [14:0] dead_interval_2,
    input wire [14:0] dead_interval_3,
    input wire [14:0] dead_interval_4,
    input wire [7:0] oc_trip,
    input wire [7:0] oc_pickup,
    input wire [7:0] trip_and_reclose_function,
    input wire ext_initiate,
    input wire breaker_contact_assigned,
    input wire breaker_closed_contact,
    input wire breaker_open_contact,
    input wire block_reclose,
    input wire cancel_reclose,
    input wire close_block,
    input wire sync_block,
    input wire breaker_fail,
    input wire panel_reset,
    input wire input_reset,
    input wire comms_reset,
    input wire manual_close_cmd,
    input wire [4:0] enabled_relay_sel,
    input wire [4:0] progress_relay_sel,
    input wire [4:0] lockout_relay_sel,
    output reg close_pulse,
    output reg [2:0] shot_count,
    output reg [2:0] prot_stage,
    output reg scheme_enabled,
    output reg in_progress,
    output reg lockout,
    output reg [4:0] aux_relays
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT_OPEN = 2'h1;
    localparam ST_DEAD = 2'h2;
    reg rs1_q, rs2_q;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end
    wire srst_n = rs2_q;

    wire tick_10ms;
    arseq_tick #(.PERIOD(TICK_CYC)) u_tick (
        .core_clk(core_clk),
        .rst_n(srst_n),
        .en(1'b1),
        .tick_q(tick_10ms)
    );
    reg [6:0] sub_q;
    reg sec_q;
    always @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            sub_q <= 7'h0;
            sec_q <= 1'b0;
        end else begin
            sec_q <= 1'b0;
            if (tick_10ms) begin
                if (sub_q == SEC_TICKS - 1) begin
                    sub_q <= 7'h0;
                    sec_q <= 1'b1;
                end else begin
                    sub_q <= sub_q + 7'h1;
                end
            end
        end
    end

    reg [1:0] st_q;
    reg [2:0] shots_q;
    reg [2:0] stage_q;
    reg lock_q, close_q;
    reg [14:0] dead_q;
    reg [9:0] rst_tmr_q, to_tmr_q;
    reg rst_run_q;
    reg [7:0] mc_tmr_q;
    reg mc_run_q, mc_lock_clear_q;
    reg brk_prev_q;
    reg [1:0] pump_q;
    reg closed_since_q;
    reg [5:0] hr_slot_q;
    reg [5:0] hr_sec_q;
    reg [5:0] hr_cnt [0:59];
    reg [11:0] hr_total_q;
    wire [5:0] hr_next = (hr_slot_q == `ARSEQ_HOUR_SLOTS - 1) ? 6'h0 : hr_slot_q + 6'h1;
    integer i;

    wire brk_open = breaker_open_contact | ~breaker_closed_contact;
    wire brk_closed = breaker_closed_contact & ~breaker_open_contact;
    wire oc_init = |(oc_trip & trip_and_reclose_function);
    wire initiate = oc_init | ext_initiate;
    wire any_trip = |oc_trip;
    wire manual_close = external_close_detect_enable ? (brk_closed & ~brk_prev_q)
                                                     : manual_close_cmd;
    wire enabled = reclose_scheme_enable & breaker_contact_assigned & ~block_reclose &
                   ~cancel_reclose & ~lock_q & ~mc_run_q;
    wire close_ok = brk_open & ~close_block & ~sync_block;
    reg [14:0] dead_sel;
    always @* begin
        case (shots_q)
            3'h0: dead_sel = dead_interval_1;
            3'h1: dead_sel = dead_interval_2;
            3'h2: dead_sel = dead_interval_3;
            default: dead_sel = dead_interval_4;
        endcase
    end
    wire [2:0] limit = (shot_limit == 3'h0) ? 3'h1 : ((shot_limit > 3'h4) ? 3'h4 : shot_limit);
    wire rate_trip = (hr_total_q > {6'h0, hourly_reclose_limit});
    wire op_reset = panel_reset | input_reset | comms_reset;

    always @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            st_q <= ST_IDLE;
            shots_q <= 3'h0;
            stage_q <= 3'h0;
            lock_q <= 1'b0;
            close_q <= 1'b0;
            dead_q <= 15'h0;
            rst_tmr_q <= 10'h0;
            rst_run_q <= 1'b0;
            to_tmr_q <= 10'h0;
            mc_tmr_q <= 8'h0;
            mc_run_q <= 1'b0;
            mc_lock_clear_q <= 1'b0;
            // idles as closed so a breaker already closed at reset is no manual close
            brk_prev_q <= 1'b1;
            pump_q <= 2'h0;
            closed_since_q <= 1'b0;
        end else begin
            close_q <= 1'b0;
            brk_prev_q <= brk_closed;
            if (manual_close) begin
                mc_run_q <= 1'b1;
                mc_tmr_q <= 8'h0;
                mc_lock_clear_q <= 1'b1;
            end else if (mc_run_q) begin
                if (any_trip) begin
                    mc_run_q <= 1'b0;
                    mc_lock_clear_q <= 1'b0;
                end else if (mc_tmr_q >= manual_close_block_interval) begin
                    mc_run_q <= 1'b0;
                    // manual close clears only without pickup
                    if (mc_lock_clear_q && oc_pickup == 8'h0) begin
                        lock_q <= 1'b0;
                        shots_q <= 3'h0;
                        stage_q <= 3'h0;
                    end
                    mc_lock_clear_q <= 1'b0;
                end else if (sec_q) begin
                    mc_tmr_q <= mc_tmr_q + 8'h1;
                end
            end
            if (rst_run_q && sec_q)
                rst_tmr_q <= rst_tmr_q + 10'h1;
            if (rst_run_q && st_q == ST_IDLE && rst_tmr_q >= sequence_reset_interval) begin
                rst_run_q <= 1'b0;
                if (pump_q >= `ARSEQ_PUMP_LIMIT) begin
                    stage_q <= 3'h0;
                end else begin
                    shots_q <= 3'h0;
                    stage_q <= 3'h0;
                end
                if (pump_q != 2'h3)
                    pump_q <= pump_q + 2'h1;
            end
            if (closed_since_q && rst_run_q == 1'b0 && any_trip == 1'b0 && lock_q)
                pump_q <= 2'h0;
            if (op_reset && !breaker_fail && !rate_trip) begin
                lock_q <= 1'b0;
                shots_q <= 3'h0;
                stage_q <= 3'h0;
                pump_q <= 2'h0;
            end
            case (st_q)
                ST_IDLE: begin
                    if (initiate && enabled) begin
                        if (shots_q >= limit) begin
                            lock_q <= 1'b1;
                        end else begin
                            st_q <= ST_WAIT_OPEN;
                            to_tmr_q <= 10'h0;
                            if (!rst_run_q) begin
                                rst_run_q <= 1'b1;
                                rst_tmr_q <= 10'h0;
                            end
                        end
                    end
                end
                ST_WAIT_OPEN: begin
                    if (close_ok) begin
                        st_q <= ST_DEAD;
                        dead_q <= 15'h0;
                    end
                end
                ST_DEAD: begin
                    if (!close_ok) begin
                        st_q <= ST_WAIT_OPEN;
                    end else if (dead_q > dead_sel) begin
                        st_q <= ST_IDLE;
                        shots_q <= shots_q + 3'h1;
                        stage_q <= shots_q + 3'h1;
                        close_q <= 1'b1;
                    end else if (tick_10ms) begin
                        dead_q <= dead_q + 15'h1;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
            if (st_q != ST_IDLE) begin
                if (to_tmr_q >= shot_timeout_interval && !close_ok)
                    st_q <= ST_IDLE;
                else if (sec_q)
                    to_tmr_q <= to_tmr_q + 10'h1;
            end
            closed_since_q <= brk_closed;
            if (breaker_fail || rate_trip || cancel_reclose || block_reclose) begin
                // lockout outranks a close decided in the same cycle
                if (breaker_fail || rate_trip) begin
                    lock_q <= 1'b1;
                    close_q <= 1'b0;
                end
                st_q <= ST_IDLE;
            end
            if (lock_q) begin
                stage_q <= 3'h0;
                st_q <= ST_IDLE;
                rst_run_q <= 1'b0;
            end
        end
    end

    always @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            hr_slot_q <= 6'h0;
            hr_sec_q <= 6'h0;
            hr_total_q <= 12'h0;
            for (i = 0; i < 60; i = i + 1)
                hr_cnt[i] <= 6'h0;
        end else begin
            if (sec_q && hr_sec_q == `ARSEQ_SLOT_S - 1) begin
                hr_sec_q <= 6'h0;
                // a close in the rollover cycle lands in the fresh slot, not lost
                hr_slot_q <= hr_next;
                hr_total_q <= hr_total_q - {6'h0, hr_cnt[hr_next]} + {11'h0, close_q};
                hr_cnt[hr_next] <= {5'h0, close_q};
            end else begin
                if (sec_q)
                    hr_sec_q <= hr_sec_q + 6'h1;
                if (close_q && hr_cnt[hr_slot_q] != 6'h3f) begin
                    hr_cnt[hr_slot_q] <= hr_cnt[hr_slot_q] + 6'h1;
                    hr_total_q <= hr_total_q + 12'h1;
                end
            end
        end
    end

    always @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            close_pulse <= 1'b0;
            shot_count <= 3'h0;
            prot_stage <= 3'h0;
            scheme_enabled <= 1'b0;
            in_progress <= 1'b0;
            lockout <= 1'b0;
            aux_relays <= 5'h0;
        end else begin
            close_pulse <= close_q;
            shot_count <= shots_q;
            prot_stage <= stage_q;
            scheme_enabled <= enabled;
            in_progress <= (st_q != ST_IDLE);
            lockout <= lock_q;
            aux_relays <= (enabled ? enabled_relay_sel : 5'h0) |
                          ((st_q != ST_IDLE) ? progress_relay_sel : 5'h0) |
                          (lock_q ? lockout_relay_sel : 5'h0);
        end
    end
endmodule // arseq_top

// ### tb/arseq_monitor.sv
// Purpose: port checker for the reclose sequencer
// Assumes: settings steady while a sequence runs
// Notes: attached to arseq_top by bind
`timescale 1ns/1ps
module arseq_monitor (
    input wire core_clk,
    input wire rst_n,
    input wire reclose_scheme_enable,
    input wire close_block,
    input wire sync_block,
    input wire breaker_fail,
    input wire [4:0] progress_relay_sel,
    input wire [4:0] lockout_relay_sel,
    input wire close_pulse,
    input wire [2:0] shot_count,
    input wire [2:0] prot_stage,
    input wire scheme_enabled,
    input wire in_progress,
    input wire lockout,
    input wire [4:0] aux_relays
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    a_shot_bound: assert property (shot_count <= 3'h4)
        else $error("shot count above four");
    a_close_single: assert property (close_pulse |=> !close_pulse)
        else $error("close pulse too long");
    a_close_stage: assert property (close_pulse |-> prot_stage == shot_count && shot_count != 3'h0)
        else $error("stage does not follow shot");
    a_lock_no_close: assert property (lockout |-> !close_pulse)
        else $error("close while locked out");
    a_lock_stage: assert property (lockout && $past(lockout) |-> prot_stage == 3'h0)
        else $error("settings not initial in lockout");
    a_fail_lock: assert property (breaker_fail |-> ##[1:4] lockout)
        else $error("breaker failure without lockout");
    a_close_unblocked: assert property (close_pulse |-> !$past(close_block, 2) && !$past(sync_block, 2))
        else $error("close while blocked");
    a_disabled_idle: assert property (!reclose_scheme_enable [*3] |-> !scheme_enabled)
        else $error("enabled with function off");
    a_progress_relays: assert property (in_progress && $past(in_progress) |-> (aux_relays & progress_relay_sel) == progress_relay_sel)
        else $error("progress relays off");
    a_lock_relays: assert property (lockout && $past(lockout) |-> (aux_relays & lockout_relay_sel) == lockout_relay_sel)
        else $error("lockout relays off");
    c_close: cover property (close_pulse);
    c_lock: cover property ($rose(lockout));
    c_progress: cover property ($rose(in_progress));
endmodule // arseq_monitor
bind arseq_top arseq_monitor i_mon (.core_clk, .rst_n, .reclose_scheme_enable, .close_block,
    .sync_block, .breaker_fail, .progress_relay_sel, .lockout_relay_sel, .close_pulse,
    .shot_count, .prot_stage, .scheme_enabled, .in_progress, .lockout, .aux_relays);

// ### tb/arseq_breaker_model.sv
// Purpose: breaker mechanism with auxiliary contacts
// Assumes: trip and close commands are levels or pulses
// Notes: OP_CYC sets how slowly the mechanism answers
`timescale 1ns/1ps
module arseq_breaker_model #(
    parameter OP_CYC = 3
) (
    input wire core_clk,
    input wire trip_cmd,
    input wire close_cmd,
    output reg closed_q = 1'b1,
    output wire open_contact
);
    reg [7:0] cnt_q = 8'h00;
    // both contacts come from one state so they never disagree mid-travel
    assign open_contact = !closed_q;
    always @(posedge core_clk) begin
        if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01)
                closed_q <= !closed_q;
        end else if ((trip_cmd && closed_q) || (close_cmd && !closed_q))
            cnt_q <= 8'(OP_CYC);
    end
endmodule // arseq_breaker_model

// ### tb/arseq_top_test.sv
// Purpose: self-checking bench for the reclose sequencer
// Assumes: shortened ticks, one second is 80 cycles
// Notes: dead intervals 2 to 5 ticks of 20 cycles
`timescale 1ns/1ps
module arseq_top_test;
    reg core_clk = 1'b0, rst_n = 1'b0, reclose_scheme_enable = 1'b1;
    reg [2:0] shot_limit = 3'h1;
    reg [9:0] sequence_reset_interval = 10'h00a, shot_timeout_interval = 10'h005;
    reg [7:0] manual_close_block_interval = 8'h02, oc_pickup = 8'h00;
    reg [5:0] hourly_reclose_limit = 6'h32;
    reg [14:0] dead_interval_1 = 15'h0002, dead_interval_2 = 15'h0003;
    reg [14:0] dead_interval_3 = 15'h0004, dead_interval_4 = 15'h0005;
    reg [7:0] oc_trip = 8'h00, trip_and_reclose_function = 8'hff;
    reg ext_initiate = 1'b0, external_close_detect_enable = 1'b0, breaker_contact_assigned = 1'b1;
    reg block_reclose = 1'b0, cancel_reclose = 1'b0, close_block = 1'b0, sync_block = 1'b0;
    reg breaker_fail = 1'b0, panel_reset = 1'b0, input_reset = 1'b0, comms_reset = 1'b0;
    reg manual_close_cmd = 1'b0, brk_close = 1'b0;
    reg [4:0] enabled_relay_sel = 5'h01, progress_relay_sel = 5'h02, lockout_relay_sel = 5'h04;
    wire close_pulse, scheme_enabled, in_progress, lockout;
    wire breaker_closed_contact, breaker_open_contact;
    wire [2:0] shot_count, prot_stage;
    wire [4:0] aux_relays;
    int n_errors = 0;
    int n_checks = 0;
    // rows: limit, trips, expected shot count, expected lockout
    int rows [6][4] = '{'{0, 2, 1, 1}, '{1, 1, 1, 0}, '{2, 3, 2, 1}, '{3, 3, 3, 0},
        '{4, 5, 4, 1}, '{7, 2, 2, 0}};
    bit got;

    arseq_top #(.TICK_CYC(20), .SEC_TICKS(4)) i_dut (.*);
    arseq_breaker_model #(.OP_CYC(3)) i_brk (.core_clk(core_clk),
        .trip_cmd(|oc_trip || ext_initiate), .close_cmd(close_pulse || brk_close),
        .closed_q(breaker_closed_contact), .open_contact(breaker_open_contact));

    initial forever #25 core_clk = ~core_clk;

    task report_and_stop;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task do_reset(input [2:0] lim);
        @(posedge core_clk);
        {rst_n, close_block, external_close_detect_enable} <= 3'h0;
        {brk_close, trip_and_reclose_function} <= 9'h1ff;
        shot_limit <= lim;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        brk_close <= 1'b0;
        repeat (8) @(posedge core_clk);
        #1;
    endtask

    task trip(input [7:0] el, input bit x);
        repeat (10) @(posedge core_clk);
        oc_trip <= el;
        ext_initiate <= x;
        repeat (8) @(posedge core_clk);
        oc_trip <= 8'h00;
        ext_initiate <= 1'b0;
        #1;
    endtask

    // a close that never comes ends the run at once
    task wait_close(input bit exp);
        got = 1'b0;
        for (int i = 0; i < 600 && !got; i++) begin
            @(posedge core_clk);
            #1;
            got = close_pulse === 1'b1;
        end
        chk("close", exp, got);
        if (exp && !got)
            report_and_stop();
    endtask

    task wait_chk(input int n, input string nm, input logic [7:0] exp, input logic [7:0] sel);
        repeat (n) @(posedge core_clk);
        #1;
        chk(nm, exp, sel ? {5'h00, prot_stage} : {5'h00, shot_count});
    endtask

    initial begin
        for (int r = 0; r < 6; r++) begin
            do_reset(rows[r][0][2:0]);
            chk("enabled", 1, scheme_enabled);
            chk("relays", 5'h01, aux_relays);
            for (int t = 0; t < rows[r][1]; t++) begin
                trip(r[0] ? 8'h00 : 8'h01 << r, r[0]);
                if (t < rows[r][2]) begin
                    chk("progress", 1, in_progress);
                    chk("relays", 5'h03, aux_relays);
                    wait_close(1);
                    chk("stage", t + 1, prot_stage);
                end
            end
            wait_chk(10, "count", rows[r][2], 0);
            chk("lockout", rows[r][3], lockout);
        end
        do_reset(3'h4);
        @(posedge core_clk);
        trip_and_reclose_function <= 8'hfe;
        external_close_detect_enable <= 1'b1;
        trip(8'h01, 0);
        chk("progress", 0, in_progress);
        @(posedge core_clk);
        brk_close <= 1'b1;
        @(posedge core_clk);
        brk_close <= 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
        chk("enabled", 0, scheme_enabled);
        repeat (200) @(posedge core_clk);
        #1;
        chk("enabled", 1, scheme_enabled);
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk);
            {reclose_scheme_enable, cancel_reclose, block_reclose, breaker_contact_assigned} <=
                4'h9 ^ (4'h1 << k);
            repeat (4) @(posedge core_clk);
            #1;
            chk("enabled", 0, scheme_enabled);
        end
        @(posedge core_clk);
        {reclose_scheme_enable, cancel_reclose, block_reclose, breaker_contact_assigned} <= 4'h9;
        for (int k = 0; k < 2; k++) begin
            do_reset(3'h4);
            @(posedge core_clk);
            {sync_block, close_block} <= 2'h1 << k;
            trip(8'h01, 0);
            repeat (100) @(posedge core_clk);
            {sync_block, close_block} <= 2'h0;
            wait_close(1);
        end
        @(posedge core_clk);
        close_block <= 1'b1;
        trip(8'h01, 0);
        wait_close(0);
        chk("progress", 0, in_progress);
        do_reset(3'h4);
        // the third automatic reset in a row keeps the shot count
        for (int k = 0; k < 3; k++) begin
            trip(8'h01, 0);
            wait_close(1);
            wait_chk(900, "count", k / 2, 0);
            chk("stage", 0, prot_stage);
        end
        trip(8'h01, 0);
        wait_close(1);
        // manual close clears lockout only with no pickup at expiry
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            {breaker_fail, oc_pickup} <= {1'b1, 7'h00, k == 0};
            @(posedge core_clk);
            {breaker_fail, manual_close_cmd} <= 2'h1;
            @(posedge core_clk);
            manual_close_cmd <= 1'b0;
            wait_chk(300, "count", k ? 0 : 2, 0);
            chk("lockout", k == 0, lockout);
        end
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk);
            breaker_fail <= 1'b1;
            wait_chk(6, "stage", 0, 1);
            chk("lockout", 1, lockout);
            chk("relays", 5'h04, aux_relays);
            @(posedge core_clk);
            breaker_fail <= 1'b0;
            {comms_reset, input_reset, panel_reset} <= 3'h1 << k;
            @(posedge core_clk);
            {comms_reset, input_reset, panel_reset} <= 3'h0;
            repeat (6) @(posedge core_clk);
            #1;
            chk("lockout", 0, lockout);
        end
        do_reset(3'h4);
        @(posedge core_clk);
        hourly_reclose_limit <= 6'h02;
        for (int k = 0; k < 3; k++) begin
            trip(8'h01, 0);
            wait_close(1);
        end
        wait_chk(10, "count", 3, 0);
        chk("lockout", 1, lockout);
        report_and_stop();
    end
endmodule // arseq_top_test
